// File: logic/cmr_pkg.sv
// Constants for the comparator status and reference register bank.
// Assumes a single 250 MHz clock and a plain strobe register port.
//
// Behaviour
// RULE_01 - Comparator two status bit follows polarity
// RULE_02 - Comparator one status bit follows polarity
// RULE_03 - Event flags mirror control register, never stored
// RULE_04 - Output flags mirror control register result bit
// RULE_05 - Alternate source needs an enabled comparator
// RULE_06 - Identifier is 24-bit read-only, writes ignored
// RULE_07 - Reference fields hold, reset zero, gaps zero
package cmr_pkg;

    // ========================================
    // Bus geometry
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam int          NUM_CMP      = 2;

    // ========================================
    // Register offsets (byte addresses)
    localparam logic [7:0]  OFS_STATUS   = 8'h00;
    localparam logic [7:0]  OFS_REFCTL   = 8'h04;
    localparam logic [7:0]  OFS_IDENT    = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STS  = 8'h0C;
    localparam logic [7:0]  OFS_IRQ_CLR  = 8'h10;
    localparam logic [7:0]  OFS_IRQ_EN   = 8'h14;

    // ========================================
    // Status word layout
    localparam int          STS_OUT_LSB  = 0;
    localparam int          STS_EVT_LSB  = 8;

    // ========================================
    // Reference control layout
    localparam int          REF_LVL_LSB  = 0;
    localparam int          REF_SS_BIT   = 4;
    localparam int          REF_RR_BIT   = 5;
    localparam int          REF_OE1_BIT  = 6;
    localparam int          REF_EN_BIT   = 7;
    localparam int          REF_ISEL_BIT = 10;
    localparam int          REF_OE2_BIT  = 14;
    localparam logic [15:0] REF_WR_MASK  = 16'h44FF;
    localparam logic [15:0] REF_RESET    = 16'h0000;

    // ========================================
    // Identifier, value arbitrary
    localparam logic [23:0] IDENT_VALUE  = 24'h00A5C3;

endpackage

// File: logic/cmr_cmp_if.sv
// Carries comparator results and event edges between sense and registers.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
interface cmr_cmp_if;
    logic [1:0] result;
    logic [1:0] event_lvl;
    logic [1:0] event_rise;

    modport sense (output result, output event_lvl, output event_rise);
    modport regs  (input result, input event_lvl, input event_rise);
endinterface

// File: logic/cmr_cmp_sense.sv
// Per-comparator result encoding and event edge detection.
// Assumes analog compare and event levels are synchronous to mclk.
`timescale 1ns/1ps
module cmr_cmp_sense (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [1:0] cmp_above,
    input  wire logic [1:0] output_polarity_invert,
    input  wire logic [1:0] comparator_event_flag,
    cmr_cmp_if.sense        cmp
);

    logic [1:0] evt_prev_ff;

    // ========================================
    // Per comparator
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_cmp
            // Polarity flips the sense of the result
            assign cmp.result[i] = cmp_above[i] ^
                                   output_polarity_invert[i]; // RULE_01
            assign cmp.event_rise[i] = comparator_event_flag[i] &
                                       ~evt_prev_ff[i];
        end
    endgenerate

    // Level passed through, not stored
    assign cmp.event_lvl = comparator_event_flag; // RULE_03

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            evt_prev_ff <= 2'h0;
        end else begin
            evt_prev_ff <= comparator_event_flag;
        end
    end

endmodule

// File: logic/cmr_regs.sv
// Register bank: comparator status, reference control, identifier, irq.
// Assumes a strobe master that never issues read and write together.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module cmr_regs (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [1:0]  cmp_above,
    input  wire logic [1:0]  output_polarity_invert,
    input  wire logic [1:0]  comparator_event_flag,
    input  wire logic [1:0]  cmp_module_enabled,
    output logic      [1:0]  comparator_result_bit,
    output logic             reference_enable,
    output logic             reference_range_select,
    output logic             reference_source_select,
    output logic             reference_pin1_output_enable,
    output logic             reference_pin2_output_enable,
    output logic             reference_input_select,
    output logic      [3:0]  reference_level_field,
    output logic             reference_active,
    output logic             irq
);

    cmr_cmp_if cmp ();

    cmr_cmp_sense u_sense (
        .mclk                   (mclk),
        .rst                    (rst),
        .cmp_above              (cmp_above),
        .output_polarity_invert (output_polarity_invert),
        .comparator_event_flag  (comparator_event_flag),
        .cmp                    (cmp)
    );

    logic [15:0] ref_ff;
    logic [15:0] nxt_ref;
    logic [1:0]  irq_sts_ff;
    logic [1:0]  nxt_irq_sts;
    logic [1:0]  irq_en_ff;
    logic [1:0]  nxt_irq_en;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // ========================================
    // Address decode
    wire         hit_status = (reg_addr == cmr_pkg::OFS_STATUS);
    wire         hit_ref    = (reg_addr == cmr_pkg::OFS_REFCTL);
    wire         hit_ident  = (reg_addr == cmr_pkg::OFS_IDENT);
    wire         hit_ists   = (reg_addr == cmr_pkg::OFS_IRQ_STS);
    wire         hit_iclr   = (reg_addr == cmr_pkg::OFS_IRQ_CLR);
    wire         hit_ien    = (reg_addr == cmr_pkg::OFS_IRQ_EN);
    wire         wr_ref     = reg_wr & hit_ref;
    wire         wr_iclr    = reg_wr & hit_iclr;
    wire         wr_ien     = reg_wr & hit_ien;

    // ========================================
    // Status word, combinational mirror only
    wire [31:0]  status_word = {22'h0,
                                cmp.event_lvl,      // RULE_03
                                6'h0,
                                cmp.result};        // RULE_04 RULE_01 RULE_02

    // Identifier has no storage, so a write cannot touch it
    wire [31:0]  ident_word = {8'h00, cmr_pkg::IDENT_VALUE}; // RULE_06

    // ========================================
    // Reference control
    // Only implemented bits are stored; gaps stay zero on readback
    assign nxt_ref = wr_ref ? (reg_wdata[15:0] & cmr_pkg::REF_WR_MASK)
                            : ref_ff; // RULE_07

    // ========================================
    // Interrupt status: set wins over clear
    assign nxt_irq_sts = cmp.event_rise |
                         (irq_sts_ff & ~({2{wr_iclr}} & reg_wdata[1:0]));
    assign nxt_irq_en  = wr_ien ? reg_wdata[1:0] : irq_en_ff;

    // ========================================
    // Read mux; unmapped reads return zero
    wire [31:0]  rd_mux =
        hit_status ? status_word :
        hit_ref    ? {16'h0, ref_ff} :
        hit_ident  ? ident_word :
        hit_ists   ? {30'h0, irq_sts_ff} :
        hit_ien    ? {30'h0, irq_en_ff} : 32'h0;
    // Data valid only in the cycle after the strobe
    assign nxt_rdata = reg_rd ? rd_mux : 32'h0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_ff     <= cmr_pkg::REF_RESET; // RULE_07
            irq_sts_ff <= 2'h0;
            irq_en_ff  <= 2'h0;
            rdata_ff   <= 32'h0;
        end else begin
            ref_ff     <= nxt_ref;
            irq_sts_ff <= nxt_irq_sts;
            irq_en_ff  <= nxt_irq_en;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ========================================
    // Outputs
    assign reg_rdata                    = rdata_ff;
    assign comparator_result_bit        = cmp.result;
    assign reference_level_field        = ref_ff[3:0];
    assign reference_source_select      = ref_ff[cmr_pkg::REF_SS_BIT];
    assign reference_range_select       = ref_ff[cmr_pkg::REF_RR_BIT];
    assign reference_pin1_output_enable = ref_ff[cmr_pkg::REF_OE1_BIT];
    assign reference_enable             = ref_ff[cmr_pkg::REF_EN_BIT];
    assign reference_input_select       = ref_ff[cmr_pkg::REF_ISEL_BIT];
    assign reference_pin2_output_enable = ref_ff[cmr_pkg::REF_OE2_BIT];
    // Alternate source is dead unless some comparator is on
    assign reference_active = reference_enable &
                              (~reference_source_select |
                               (|cmp_module_enabled)); // RULE_05
    assign irq = |(irq_sts_ff & irq_en_ff);

    // ========================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence

    sequence s_wr(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence

    property p_cmp2_sense;
        s_rd(cmr_pkg::OFS_STATUS) |=>
            reg_rdata[1] == $past(cmp_above[1] ^ output_polarity_invert[1]);
    endproperty
    a_cmp2_sense: assert property (p_cmp2_sense) // RULE_01
        else $error("comparator two status bit wrong");

    property p_cmp1_sense;
        s_rd(cmr_pkg::OFS_STATUS) |=>
            reg_rdata[0] == $past(cmp_above[0] ^ output_polarity_invert[0]);
    endproperty
    a_cmp1_sense: assert property (p_cmp1_sense) // RULE_02
        else $error("comparator one status bit wrong");

    property p_evt_mirror;
        s_rd(cmr_pkg::OFS_STATUS) |=>
            reg_rdata[9:8] == $past(comparator_event_flag);
    endproperty
    a_evt_mirror: assert property (p_evt_mirror) // RULE_03
        else $error("event flags not mirrored");

    property p_out_mirror;
        s_rd(cmr_pkg::OFS_STATUS) |=>
            reg_rdata[1:0] == $past(comparator_result_bit);
    endproperty
    a_out_mirror: assert property (p_out_mirror) // RULE_04
        else $error("output flags not mirrored");

    property p_ident;
        s_wr(cmr_pkg::OFS_IDENT) ##1 s_rd(cmr_pkg::OFS_IDENT) |=>
            reg_rdata == {8'h00, cmr_pkg::IDENT_VALUE};
    endproperty
    a_ident: assert property (p_ident) // RULE_06
        else $error("identifier changed or misread");

    property p_ref_rw;
        s_wr(cmr_pkg::OFS_REFCTL) ##1 s_rd(cmr_pkg::OFS_REFCTL) |=>
            reg_rdata == {16'h0, $past(reg_wdata[15:0], 2) &
                                 cmr_pkg::REF_WR_MASK};
    endproperty
    a_ref_rw: assert property (p_ref_rw) // RULE_07
        else $error("reference readback wrong");

    property p_ref_hold;
        !wr_ref |=> $stable(ref_ff);
    endproperty
    a_ref_hold: assert property (p_ref_hold) // RULE_07
        else $error("reference register changed without write");

    property p_ref_src;
        reference_enable && reference_source_select &&
        cmp_module_enabled == 2'h0 |-> !reference_active;
    endproperty
    a_ref_src: assert property (p_ref_src) // RULE_05
        else $error("alternate source active with no comparator");

    property p_rd_one_cycle;
        !reg_rd |=> reg_rdata == 32'h0;
    endproperty
    a_rd_one_cycle: assert property (p_rd_one_cycle)
        else $error("read data outside its cycle");

    // Edge on any comparator event level
    sequence s_evt_rise;
        cmp.event_rise != 2'h0;
    endsequence

    // Set must win even against a clear in the same cycle
    property p_evt_latch;
        s_evt_rise |=>
            (irq_sts_ff & $past(cmp.event_rise)) == $past(cmp.event_rise);
    endproperty
    a_evt_latch: assert property (p_evt_latch)
        else $error("event edge not latched into interrupt status");

    property p_irq_clear;
        s_wr(cmr_pkg::OFS_IRQ_CLR) ##0 cmp.event_rise == 2'h0 |=>
            (irq_sts_ff & $past(reg_wdata[1:0])) == 2'h0;
    endproperty
    a_irq_clear: assert property (p_irq_clear)
        else $error("interrupt status not cleared by write");

    property p_ref_write;
        s_wr(cmr_pkg::OFS_REFCTL) |=>
            ref_ff == ($past(reg_wdata[15:0]) & cmr_pkg::REF_WR_MASK);
    endproperty
    a_ref_write: assert property (p_ref_write) // RULE_07
        else $error("reference write did not land");

endmodule

// File: testbench/cmr_analog_model.sv
// Behavioural comparators at the far side of the bank.
// Assumes the bench commands levels; they move only after mclk rises.
`timescale 1ns/1ps
module cmr_analog_model (
    input  wire logic       mclk,
    input  wire logic [1:0] cmd_above,
    input  wire logic [1:0] cmd_pol,
    input  wire logic [1:0] cmd_evt,
    input  wire logic [1:0] cmd_en,
    output logic      [1:0] cmp_above,
    output logic      [1:0] output_polarity_invert,
    output logic      [1:0] comparator_event_flag,
    output logic      [1:0] cmp_module_enabled
);
    // ========================================
    // Levels
    // Registered so every change lands one edge after the command
    initial begin
        cmp_above              = 2'h0;
        output_polarity_invert = 2'h0;
        comparator_event_flag  = 2'h0;
        cmp_module_enabled     = 2'h0;
    end
    always @(posedge mclk) begin
        cmp_above              <= cmd_above;
        output_polarity_invert <= cmd_pol;
        comparator_event_flag  <= cmd_evt;
        cmp_module_enabled     <= cmd_en;
    end
endmodule

// File: testbench/cmr_regs_test.sv
// Self-checking bench for the comparator status and reference bank.
// Assumes the strobe register port and the analog model beside it.
`timescale 1ns/1ps
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module cmr_regs_test;
    // ========================================
    // Signals
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [1:0]  cmd_above = 2'h0, cmd_pol = 2'h0;
    logic [1:0]  cmd_evt = 2'h0, cmd_en = 2'h0;
    logic [1:0]  above, pol, evt, en, res;
    logic        ref_en, ref_rr, ref_ss, oe1, oe2, isel, active, irq;
    logic [3:0]  lvl;
    int          err_total = 0;
    int          n_checks = 0;
    always #2 mclk = ~mclk;

    cmr_analog_model u_cmr_analog_model (.mclk(mclk), .cmd_above(cmd_above),
        .cmd_pol(cmd_pol), .cmd_evt(cmd_evt), .cmd_en(cmd_en),
        .cmp_above(above), .output_polarity_invert(pol),
        .comparator_event_flag(evt), .cmp_module_enabled(en));
    cmr_regs u_cmr_regs (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmp_above(above),
        .output_polarity_invert(pol), .comparator_event_flag(evt),
        .cmp_module_enabled(en), .comparator_result_bit(res),
        .reference_enable(ref_en), .reference_range_select(ref_rr),
        .reference_source_select(ref_ss),
        .reference_pin1_output_enable(oe1),
        .reference_pin2_output_enable(oe2),
        .reference_input_select(isel), .reference_level_field(lvl),
        .reference_active(active), .irq(irq));

    // ========================================
    // Tasks
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        `CHK(reg_rdata, exp);
    endtask
    // Write then read with no idle cycle between the strobes
    task automatic wrrd(input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] exp);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge mclk);
        reg_rd    <= 1'b0;
        #1;
        `CHK(reg_rdata, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ========================================
    // Tests
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rchk(cmr_pkg::OFS_REFCTL, 32'h0000_0000);
        rchk(cmr_pkg::OFS_IDENT, {8'h00, cmr_pkg::IDENT_VALUE});
        rchk(8'h20, 32'h0000_0000);
        $display("test reset values done");
        wr(cmr_pkg::OFS_REFCTL, 32'hFFFF_FFFF);
        `CHK({oe2, isel, ref_en, oe1, ref_rr, ref_ss, lvl}, 10'h3FF);
        rchk(cmr_pkg::OFS_REFCTL, 32'h0000_44FF);
        wr(cmr_pkg::OFS_IDENT, 32'h0000_0000);
        rchk(cmr_pkg::OFS_IDENT, {8'h00, cmr_pkg::IDENT_VALUE});
        wrrd(cmr_pkg::OFS_IDENT, 32'hFFFF_FFFF,
             {8'h00, cmr_pkg::IDENT_VALUE});
        wrrd(cmr_pkg::OFS_REFCTL, 32'hFFFF_0409, 32'h0000_0409);
        `CHK({oe2, isel, ref_en, oe1, ref_rr, ref_ss, lvl}, 10'h109);
        $display("test reference register done");
        wr(cmr_pkg::OFS_REFCTL, 32'h0000_0090);
        `CHK({oe2, isel, ref_en, oe1, ref_rr, ref_ss, lvl}, 10'h090);
        `CHK(active, 1'b0);
        cmd_en <= 2'h2;
        settle();
        `CHK(active, 1'b1);
        $display("test source select done");
        for (int i = 0; i < 16; i++) begin
            @(posedge mclk);
            cmd_above <= i[1:0];
            cmd_pol   <= i[3:2];
            settle();
            `CHK(res, i[1:0] ^ i[3:2]);
            rchk(cmr_pkg::OFS_STATUS, 32'(i[1:0] ^ i[3:2]));
        end
        $display("test polarity done");
        wr(cmr_pkg::OFS_IRQ_EN, 32'h0000_0001);
        cmd_evt <= 2'h3;
        settle();
        rchk(cmr_pkg::OFS_STATUS, 32'h0000_0300);
        rchk(cmr_pkg::OFS_IRQ_STS, 32'h0000_0003);
        `CHK(irq, 1'b1);
        wr(cmr_pkg::OFS_IRQ_EN, 32'h0000_0000);
        `CHK(irq, 1'b0);
        wr(cmr_pkg::OFS_IRQ_CLR, 32'h0000_0001);
        wr(cmr_pkg::OFS_IRQ_EN, 32'h0000_0003);
        rchk(cmr_pkg::OFS_IRQ_STS, 32'h0000_0002);
        `CHK(irq, 1'b1);
        wr(cmr_pkg::OFS_IRQ_CLR, 32'h0000_0002);
        `CHK(irq, 1'b0);
        cmd_evt <= 2'h1;
        settle();
        rchk(cmr_pkg::OFS_STATUS, 32'h0000_0100);
        $display("test events done");
        wr(cmr_pkg::OFS_REFCTL, 32'h0000_44FF);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk(cmr_pkg::OFS_REFCTL, 32'h0000_0000);
        `CHK({oe2, isel, ref_en, oe1, ref_rr, ref_ss, lvl}, 10'h000);
        $display("test second reset done");
        stop_test();
    end
    // Tests need well under 2000 cycles
    initial begin
        #20000;
        err_total++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
